// ===== ddr_pin_pkg.sv
package ddr_pin_pkg;

    localparam int ADDR_W    = 15;
    localparam int BANK_W    = 3;
    localparam int NUM_BANKS = 8;
    localparam int DATA_W    = 8;
    localparam int MEM_DEPTH = 64;

    // Address bit positions with a special meaning.
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;

    // Mode register field positions.
    localparam int BL_LSB      = 0;
    localparam int BL_MSB      = 1;
    localparam int RTT_B0      = 2;
    localparam int RTT_B1      = 6;
    localparam int RTT_B2      = 9;
    localparam int TSTROBE_BIT = 11;

    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF    = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;

    localparam logic [ADDR_W-1:0] MODE_RST = 15'h0000;
    localparam logic [1:0]        MR_ZERO  = 2'h0;
    localparam logic [1:0]        MR_ONE   = 2'h1;

    localparam logic [3:0] BEATS_FULL = 4'h8;
    localparam logic [3:0] BEATS_CHOP = 4'h4;

    // Link clock is the system clock divided by four.
    localparam int         CLK_PERIOD_NS  = 8;
    localparam int         LINK_PERIOD_NS = 32;
    localparam int         CK_DIV         = LINK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [1:0] PH_FALL        = 2'(CK_DIV - 1);
    localparam logic [1:0] PH_CAPTURE     = 2'h0;

    typedef enum logic [2:0] {
        CMD_MODE      = 3'h0,
        CMD_REFRESH   = 3'h1,
        CMD_PRECHARGE = 3'h2,
        CMD_ACTIVATE  = 3'h3,
        CMD_WRITE     = 3'h4,
        CMD_READ      = 3'h5,
        CMD_ZQCAL     = 3'h6,
        CMD_NOP       = 3'h7
    } cmd_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE   = 2'h0,
        PWR_PD_PRE   = 2'h1,
        PWR_PD_ACT   = 2'h3,
        PWR_SELF_REF = 2'h2
    } pwr_t;

    function automatic logic [3:0] burst_beats(input logic [1:0] bl_mode,
                                               input logic       chop_n);
        if (bl_mode == BL_OTF)
            return chop_n ? BEATS_FULL : BEATS_CHOP;
        if (bl_mode == BL_FIXED4)
            return BEATS_CHOP;
        return BEATS_FULL;
    endfunction

endpackage

// ===== ddr_link_if.sv
interface ddr_link_if;
    logic                             ck;
    logic                             reset_n;
    logic                             cke;
    logic                             cs_n;
    logic                             ras_n;
    logic                             cas_n;
    logic                             we_n;
    logic                             termination_enable;
    logic                             dm;
    logic [ddr_pin_pkg::BANK_W-1:0]   ba;
    logic [ddr_pin_pkg::ADDR_W-1:0]   addr;
    logic [ddr_pin_pkg::DATA_W-1:0]   dq_wr;
    logic [ddr_pin_pkg::DATA_W-1:0]   dq_rd;

    modport dev (
        input  ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, termination_enable, dm, ba, addr, dq_wr,
        output dq_rd
    );

    modport ctl (
        output ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, termination_enable, dm, ba, addr, dq_wr,
        input  dq_rd
    );
endinterface

// ===== ddr_dev.sv
// Notes on behaviour
// - Precharge: address bit ten selects all banks.
// - Activate takes row, read/write takes column.
// - Mode load stores address as operation code.
// - On-the-fly: chop select picks eight or four.
// - Bank inputs name the targeted bank.
// - Mode load: bank inputs pick register zero-three.
// - Inputs captured on rising link clock.
// - Clock gate registered low stops internal activity.
// - Clock gate low: idle powers down, else active.
// - Clock gate synchronous except self refresh exit.
// - Power-down ignores all but clock-gate, reset, termination.
// - Self refresh ignores all but clock-gate, reset.
// - Device select high masks every command.
// - Strobes plus select encode the command.
// - Masked write beats leave memory unchanged.
// - Termination strobe mode disables write masking.
// - Termination follows registered termination enable.
// - Termination enable ignored when mode disables it.
// - Reset is active low and asynchronous.
module ddr_dev (
    // Link to the controller
    ddr_link_if.dev                          link,
    // Observed device state
    output ddr_pin_pkg::pwr_t                POWER_STATE_O,
    output logic [ddr_pin_pkg::NUM_BANKS-1:0] BANK_OPEN_O,
    output logic                             TERM_ON_O,
    output logic                             TERM_STROBE_O,
    // Decoded command report
    output logic                             CMD_VALID_O,
    output ddr_pin_pkg::cmd_t                CMD_CODE_O,
    output logic [ddr_pin_pkg::BANK_W-1:0]   CMD_BANK_O,
    output logic [ddr_pin_pkg::ADDR_W-1:0]   CMD_ADDR_O,
    // Write beat discarded by the mask
    output logic                             BEAT_DROP_O
);

    typedef struct packed {
        ddr_pin_pkg::pwr_t                          pwr;
        logic [ddr_pin_pkg::NUM_BANKS-1:0]          open;
        logic [3:0][ddr_pin_pkg::ADDR_W-1:0]        mr;
        logic                                       term;
        logic [3:0]                                 left;
        logic                                       bwr;
        logic [ddr_pin_pkg::BANK_W-1:0]             bbank;
        logic [2:0]                                 bcol;
        logic [ddr_pin_pkg::DATA_W-1:0]             rd;
        logic                                       cmd_v;
        ddr_pin_pkg::cmd_t                          cmd;
        logic [ddr_pin_pkg::BANK_W-1:0]             cbank;
        logic [ddr_pin_pkg::ADDR_W-1:0]             caddr;
        logic                                       drop;
    } dev_state_t;

    localparam dev_state_t STATE_RST = '{
        pwr:   ddr_pin_pkg::PWR_ACTIVE,
        open:  '0,
        mr:    {4{ddr_pin_pkg::MODE_RST}},
        term:  1'b0,
        left:  4'h0,
        bwr:   1'b0,
        bbank: 3'h0,
        bcol:  3'h0,
        rd:    8'h00,
        cmd_v: 1'b0,
        cmd:   ddr_pin_pkg::CMD_NOP,
        cbank: 3'h0,
        caddr: 15'h0000,
        drop:  1'b0
    };

    dev_state_t                      q;
    dev_state_t                      d;
    logic [ddr_pin_pkg::DATA_W-1:0]  mem [0:ddr_pin_pkg::MEM_DEPTH-1];
    logic                            mem_we;
    logic [5:0]                      mem_idx;
    logic                            cs_sel;
    ddr_pin_pkg::cmd_t               cmd;
    ddr_pin_pkg::pwr_t               pwr_now;
    logic                            rtt_off;
    logic                            tstrobe_en;

    always_comb
    begin
        d          = q;
        d.cmd_v    = 1'b0;
        d.drop     = 1'b0;
        mem_we     = 1'b0;
        mem_idx    = {q.bbank, q.bcol};
        cs_sel     = ~link.cs_n;
        cmd        = ddr_pin_pkg::cmd_t'({link.ras_n, link.cas_n, link.we_n});
        tstrobe_en = q.mr[ddr_pin_pkg::MR_ONE][ddr_pin_pkg::TSTROBE_BIT];
        rtt_off    = ~(q.mr[ddr_pin_pkg::MR_ONE][ddr_pin_pkg::RTT_B0]
                     | q.mr[ddr_pin_pkg::MR_ONE][ddr_pin_pkg::RTT_B1]
                     | q.mr[ddr_pin_pkg::MR_ONE][ddr_pin_pkg::RTT_B2]);

        // Leaving self refresh needs no edge: a high clock gate wakes the
        // decoder at once, so the first edge already sees an active device.
        if (q.pwr == ddr_pin_pkg::PWR_SELF_REF && link.cke)
            pwr_now = ddr_pin_pkg::PWR_ACTIVE;
        else
            pwr_now = q.pwr;

        // One beat per link clock edge while a burst is open.
        if (q.left != 4'h0)
        begin
            if (q.bwr)
            begin
                mem_we = tstrobe_en | ~link.dm;
                d.drop = ~mem_we;
            end
            else
            begin
                d.rd = mem[mem_idx];
            end
            d.bcol = q.bcol + 3'h1;
            d.left = q.left - 4'h1;
        end

        case (pwr_now)
            ddr_pin_pkg::PWR_ACTIVE:
            begin
                d.term = link.termination_enable & ~rtt_off;
                if (!link.cke)
                begin
                    if (q.open != '0)
                        d.pwr = ddr_pin_pkg::PWR_PD_ACT;
                    else if (cs_sel && cmd == ddr_pin_pkg::CMD_REFRESH)
                        d.pwr = ddr_pin_pkg::PWR_SELF_REF;
                    else
                        d.pwr = ddr_pin_pkg::PWR_PD_PRE;
                end
                else if (cs_sel)
                begin
                    d.pwr   = ddr_pin_pkg::PWR_ACTIVE;
                    d.cmd_v = 1'b1;
                    d.cmd   = cmd;
                    d.cbank = link.ba;
                    d.caddr = link.addr;
                    case (cmd)
                        ddr_pin_pkg::CMD_MODE:
                        begin
                            if (!link.ba[2])
                                d.mr[link.ba[1:0]] = link.addr;
                        end
                        ddr_pin_pkg::CMD_ACTIVATE:
                        begin
                            d.open[link.ba] = 1'b1;
                        end
                        ddr_pin_pkg::CMD_PRECHARGE:
                        begin
                            if (link.addr[ddr_pin_pkg::AP_BIT])
                                d.open = '0;
                            else
                                d.open[link.ba] = 1'b0;
                        end
                        ddr_pin_pkg::CMD_WRITE, ddr_pin_pkg::CMD_READ:
                        begin
                            d.left  = ddr_pin_pkg::burst_beats(
                                          q.mr[ddr_pin_pkg::MR_ZERO][ddr_pin_pkg::BL_MSB:
                                                                   ddr_pin_pkg::BL_LSB],
                                          link.addr[ddr_pin_pkg::BC_BIT]);
                            d.bwr   = (cmd == ddr_pin_pkg::CMD_WRITE);
                            d.bbank = link.ba;
                            d.bcol  = link.addr[2:0];
                            if (link.addr[ddr_pin_pkg::AP_BIT])
                                d.open[link.ba] = 1'b0;
                        end
                        default:
                        begin
                        end
                    endcase
                end
                else
                begin
                    d.pwr = ddr_pin_pkg::PWR_ACTIVE;
                end
            end
            ddr_pin_pkg::PWR_PD_PRE, ddr_pin_pkg::PWR_PD_ACT:
            begin
                // Only the clock gate and termination enable are heard here.
                d.term = link.termination_enable & ~rtt_off;
                if (link.cke)
                    d.pwr = ddr_pin_pkg::PWR_ACTIVE;
            end
            default:
            begin
                d.term = 1'b0;
            end
        endcase
    end

    always_ff @(posedge link.ck or negedge link.reset_n)
    begin
        if (!link.reset_n)
            q <= STATE_RST;
        else
            q <= d;
    end

    // Array contents are not reset; a masked beat reaches it only in termination strobe mode.
    always_ff @(posedge link.ck)
    begin
        if (mem_we)
            mem[mem_idx] <= link.dq_wr;
    end

    assign link.dq_rd    = q.rd;
    assign POWER_STATE_O = q.pwr;
    assign BANK_OPEN_O   = q.open;
    assign TERM_ON_O     = q.term;
    assign TERM_STROBE_O = q.mr[ddr_pin_pkg::MR_ONE][ddr_pin_pkg::TSTROBE_BIT];
    assign CMD_VALID_O   = q.cmd_v;
    assign CMD_CODE_O    = q.cmd;
    assign CMD_BANK_O    = q.cbank;
    assign CMD_ADDR_O    = q.caddr;
    assign BEAT_DROP_O   = q.drop;

endmodule // ddr_dev

// ===== ddr_ctl.sv
module ddr_ctl (
    // Clock and reset
    input  wire logic                           CLK_I,
    input  wire logic                           RST_N_I,
    // Command request
    input  wire logic                           CMD_VALID_I,
    input  wire ddr_pin_pkg::cmd_t              CMD_I,
    input  wire logic [ddr_pin_pkg::BANK_W-1:0] BANK_I,
    input  wire logic [ddr_pin_pkg::ADDR_W-1:0] ADDR_I,
    input  wire logic [63:0]                    WDATA_I,
    input  wire logic [7:0]                     WMASK_I,
    output logic                                CMD_READY_O,
    // Pin levels
    input  wire logic                           CKE_I,
    input  wire logic                           ODT_I,
    // Read answer
    output logic [63:0]                         RDATA_O,
    output logic                                RDATA_VALID_O,
    // Link to the device
    ddr_link_if.ctl                             link
);

    typedef enum logic [1:0] {
        C_IDLE = 2'h0,
        C_DATA = 2'h1
    } ctl_st_t;

    typedef struct packed {
        logic [1:0]                      ph;
        logic                            ck;
        logic                            rst_n;
        logic                            cke;
        logic                            termination_enable;
        logic                            cs_n;
        ddr_pin_pkg::cmd_t               cmd;
        logic [ddr_pin_pkg::BANK_W-1:0]  ba;
        logic [ddr_pin_pkg::ADDR_W-1:0]  addr;
        logic                            dm;
        logic [7:0]                      dq;
        ctl_st_t                         st;
        logic [3:0]                      len;
        logic [3:0]                      idx;
        logic                            isrd;
        logic                            take;
        logic                            last;
        logic [63:0]                     wd;
        logic [7:0]                      wm;
        logic [63:0]                     rd;
        logic                            rvalid;
        logic                            ready;
        logic [1:0]                      mr0bl;
        logic [7:0]                      sync1;
        logic [7:0]                      sync2;
    } ctl_state_t;

    ctl_state_t  q;
    ctl_state_t  d;
    logic [63:0] rd_next;

    always_comb
    begin
        d        = q;
        d.ph     = q.ph + 2'h1;
        d.ck     = d.ph[1];
        d.rst_n  = 1'b1;
        d.rvalid = 1'b0;
        d.sync1  = link.dq_rd;
        d.sync2  = q.sync1;
        rd_next  = {q.sync2, q.rd[63:8]};

        // Pins change on the falling link edge, half a period before sampling.
        if (q.ph == ddr_pin_pkg::PH_FALL)
        begin
            d.cke  = CKE_I;
            d.termination_enable  = ODT_I;
            d.cs_n = 1'b1;
            d.cmd  = ddr_pin_pkg::CMD_NOP;
            d.dm   = 1'b0;
            case (q.st)
                C_IDLE:
                begin
                    if (q.ready && CMD_VALID_I)
                    begin
                        d.cs_n = 1'b0;
                        d.cmd  = CMD_I;
                        d.ba   = BANK_I;
                        d.addr = ADDR_I;
                        d.len  = ddr_pin_pkg::burst_beats(q.mr0bl,
                                     ADDR_I[ddr_pin_pkg::BC_BIT]);
                        d.idx  = 4'h1;
                        d.isrd = (CMD_I == ddr_pin_pkg::CMD_READ);
                        d.wd   = WDATA_I;
                        d.wm   = WMASK_I;
                        if (CMD_I == ddr_pin_pkg::CMD_READ || CMD_I == ddr_pin_pkg::CMD_WRITE)
                            d.st = C_DATA;
                        if (CMD_I == ddr_pin_pkg::CMD_MODE && BANK_I == 3'h0)
                            d.mr0bl = ADDR_I[ddr_pin_pkg::BL_MSB:ddr_pin_pkg::BL_LSB];
                    end
                end
                default:
                begin
                    d.idx = q.idx + 4'h1;
                    if (!q.isrd)
                    begin
                        d.dq = q.wd[7:0];
                        d.dm = q.wm[0];
                        d.wd = {8'h00, q.wd[63:8]};
                        d.wm = {1'b0, q.wm[7:1]};
                        if (q.idx == q.len)
                            d.st = C_IDLE;
                    end
                    else
                    begin
                        d.take = (q.idx >= 4'h2);
                        d.last = (q.idx == q.len + 4'h1);
                        if (d.last)
                            d.st = C_IDLE;
                    end
                end
            endcase
        end

        // Read beats are taken one edge after the fall, once both sync stages hold them.
        if (q.ph == ddr_pin_pkg::PH_CAPTURE && q.take)
        begin
            d.take = 1'b0;
            d.last = 1'b0;
            d.rd   = rd_next;
            if (q.last)
            begin
                d.rvalid = 1'b1;
                if (q.len == ddr_pin_pkg::BEATS_CHOP)
                    d.rd = {32'h0000_0000, rd_next[63:32]};
            end
        end

        d.ready = (d.st == C_IDLE) && (d.ph == ddr_pin_pkg::PH_FALL);
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            q <= '{cmd: ddr_pin_pkg::CMD_NOP, st: C_IDLE, cs_n: 1'b1, default: '0};
        else
            q <= d;
    end

    assign link.ck      = q.ck;
    assign link.reset_n = q.rst_n;
    assign link.cke     = q.cke;
    assign link.termination_enable     = q.termination_enable;
    assign link.cs_n    = q.cs_n;
    assign link.ras_n   = q.cmd[2];
    assign link.cas_n   = q.cmd[1];
    assign link.we_n    = q.cmd[0];
    assign link.ba      = q.ba;
    assign link.addr    = q.addr;
    assign link.dm      = q.dm;
    assign link.dq_wr   = q.dq;
    assign CMD_READY_O  = q.ready;
    assign RDATA_O      = q.rd;
    assign RDATA_VALID_O = q.rvalid;

endmodule // ddr_ctl

// ===== ddr_link_chk.sv
module ddr_link_chk (
    // Controller clock and reset
    input wire logic                           CLK_I,
    input wire logic                           RST_N_I,
    // Link pins
    input wire logic                           ck,
    input wire logic                           reset_n,
    input wire logic                           cke,
    input wire logic                           termination_enable,
    input wire logic                           cs_n,
    input wire logic                           ras_n,
    input wire logic                           cas_n,
    input wire logic                           we_n,
    input wire logic                           dm,
    input wire logic [ddr_pin_pkg::BANK_W-1:0] ba,
    input wire logic [ddr_pin_pkg::ADDR_W-1:0] addr,
    input wire logic [ddr_pin_pkg::DATA_W-1:0] dq_wr
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    logic [2:0] code;
    assign code = {ras_n, cas_n, we_n};

    property p_ck_period;
        $rose(ck) |=> !$rose(ck) [*3] ##1 $rose(ck);
    endproperty
    a_ck_period: assert property (p_ck_period)
        else $error("link clock period is not four controller cycles");

    property p_cmd_at_fall;
        !$stable({cs_n, ras_n, cas_n, we_n, ba, addr}) |-> $fell(ck);
    endproperty
    a_cmd_at_fall: assert property (p_cmd_at_fall)
        else $error("command pins moved away from a link falling edge");

    property p_data_at_fall;
        !$stable({dm, dq_wr}) |-> $fell(ck);
    endproperty
    a_data_at_fall: assert property (p_data_at_fall)
        else $error("write beat or mask moved away from a link falling edge");

    property p_gate_at_fall;
        !$stable({cke, termination_enable}) |-> $fell(ck);
    endproperty
    a_gate_at_fall: assert property (p_gate_at_fall)
        else $error("clock gate or termination enable moved off a falling edge");

    property p_sel_hold;
        $fell(cs_n) |-> !cs_n [*4];
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("device select did not stand one link period");

    property p_fields_hold;
        $fell(cs_n) |=> $stable({ras_n, cas_n, we_n, ba, addr}) [*3];
    endproperty
    a_fields_hold: assert property (p_fields_hold)
        else $error("bank or address changed while a command stood");

    property p_wr_release;
        $fell(cs_n) && code == ddr_pin_pkg::CMD_WRITE |-> ##4 cs_n;
    endproperty
    a_wr_release: assert property (p_wr_release)
        else $error("device select not released during write beats");

    property p_reset_quiet;
        !reset_n |-> cs_n && !cke && !termination_enable && !ck;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("link not quiet while the device is held in reset");

    c_write: cover property ($fell(cs_n) && code == ddr_pin_pkg::CMD_WRITE);
    c_read: cover property ($fell(cs_n) && code == ddr_pin_pkg::CMD_READ);
    c_pre_all: cover property ($fell(cs_n) && code == ddr_pin_pkg::CMD_PRECHARGE
                              && addr[ddr_pin_pkg::AP_BIT]);
    c_gate_low: cover property ($fell(cke));
endmodule // ddr_link_chk

// ===== tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              valid = 1'b0;
    ddr_pin_pkg::cmd_t cmd = ddr_pin_pkg::CMD_NOP;
    logic [2:0]        bank = 3'h0;
    logic [14:0]       addr = 15'h0000;
    logic [63:0]       wdata = 64'h0;
    logic [7:0]        wmask = 8'h00;
    logic              cke = 1'b0;
    logic              termination_enable = 1'b0;
    logic              ready;
    logic              rvalid;
    logic [63:0]       rdata;
    ddr_pin_pkg::pwr_t pwr;
    logic [7:0]        opened;
    logic              term_on;
    logic              term_strobe;
    logic              drop;
    logic              dvalid;
    ddr_pin_pkg::cmd_t dcode;
    logic [2:0]        dbank;
    logic [14:0]       daddr;
    int                bad_count = 0;
    int                comparisons = 0;
    int                drops = 0;
    int                decoded = 0;
    ddr_pin_pkg::cmd_t codes [4] = '{ddr_pin_pkg::CMD_REFRESH, ddr_pin_pkg::CMD_ZQCAL,
                                     ddr_pin_pkg::CMD_MODE, ddr_pin_pkg::CMD_MODE};

    always #4 clk = ~clk;

    ddr_link_if link ();

    ddr_ctl u_ddr_ctl (.CLK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(valid), .CMD_I(cmd),
        .BANK_I(bank), .ADDR_I(addr), .WDATA_I(wdata), .WMASK_I(wmask), .CMD_READY_O(ready),
        .CKE_I(cke), .ODT_I(termination_enable), .RDATA_O(rdata), .RDATA_VALID_O(rvalid), .link(link));

    ddr_dev u_ddr_dev (.link(link), .POWER_STATE_O(pwr), .BANK_OPEN_O(opened),
        .TERM_ON_O(term_on), .TERM_STROBE_O(term_strobe), .CMD_VALID_O(dvalid), .CMD_CODE_O(dcode),
        .CMD_BANK_O(dbank), .CMD_ADDR_O(daddr), .BEAT_DROP_O(drop));

    ddr_link_chk u_ddr_link_chk (.CLK_I(clk), .RST_N_I(rst_n), .ck(link.ck),
        .reset_n(link.reset_n), .cke(link.cke), .termination_enable(link.termination_enable), .cs_n(link.cs_n),
        .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .dm(link.dm),
        .ba(link.ba), .addr(link.addr), .dq_wr(link.dq_wr));

    // Each discarded beat pulses for exactly one link cycle.
    always @(negedge link.ck)
        if (drop === 1'b1)
            drops++;

    // Every decoded command pulses for exactly one link cycle.
    always @(negedge link.ck)
        if (dvalid === 1'b1)
            decoded++;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (bad_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // The gate level is applied at the taking edge so it meets the command.
    task automatic issue(input ddr_pin_pkg::cmd_t c, input logic [2:0] b, input logic [14:0] a,
                         input logic [63:0] d = 64'h0, input logic [7:0] m = 8'h00,
                         input logic g = 1'b1);
        int n;
        n = 0;
        cmd = c;
        bank = b;
        addr = a;
        wdata = d;
        wmask = m;
        valid = 1'b1;
        while (ready !== 1'b1)
        begin
            @(negedge clk);
            n++;
            if (n > 200)
            begin
                bad_count++;
                summarize();
            end
        end
        cke = g;
        @(negedge clk);
        valid = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [14:0] a, input logic [63:0] exp, input logic [63:0] keep);
        int n;
        n = 0;
        issue(ddr_pin_pkg::CMD_READ, 3'h2, a);
        while (rvalid !== 1'b1)
        begin
            @(negedge clk);
            n++;
            if (n > 200)
            begin
                bad_count++;
                summarize();
            end
        end
        check(rdata & keep, exp);
    endtask

    initial
    begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        cke = 1'b1;
        // The device sees the reset level of the gate first and must wake before any command.
        idle(12);
        issue(ddr_pin_pkg::CMD_MODE, 3'h1, 15'h0004);
        issue(ddr_pin_pkg::CMD_MODE, 3'h0, 15'(ddr_pin_pkg::BL_OTF));
        idle(12);
        check(64'(daddr), 64'(ddr_pin_pkg::BL_OTF));
        termination_enable = 1'b1;
        idle(16);
        check(64'(term_on), 64'h1);
        termination_enable = 1'b0;
        idle(16);
        check(64'(term_on), 64'h0);
        foreach (codes[i])
        begin
            issue(codes[i], 3'(i), 15'h0000);
            idle(12);
            check(64'(dcode), 64'(codes[i]));
            check(64'(dbank), 64'(i));
        end
        issue(ddr_pin_pkg::CMD_ACTIVATE, 3'h2, 15'h1234);
        issue(ddr_pin_pkg::CMD_ACTIVATE, 3'h5, 15'h1234);
        idle(12);
        check(64'(opened), 64'h24);
        check(64'(daddr), 64'h1234);
        check(64'(decoded), 64'h8);
        issue(ddr_pin_pkg::CMD_WRITE, 3'h2, 15'h1000, 64'h8877665544332211);
        issue(ddr_pin_pkg::CMD_WRITE, 3'h2, 15'h1000, 64'hF0E0D0C0B0A09080, 8'h02);
        rd(15'h1000, 64'hF0E0D0C0B0A02280, '1);
        check(64'(drops), 64'h1);
        issue(ddr_pin_pkg::CMD_WRITE, 3'h2, 15'h0000, 64'hDDCCBBAA);
        rd(15'h1000, 64'hF0E0D0C0DDCCBBAA, '1);
        rd(15'h0000, 64'h00000000DDCCBBAA, '1);
        issue(ddr_pin_pkg::CMD_MODE, 3'h1, 15'h0800);
        termination_enable = 1'b1;
        idle(16);
        check(64'(term_strobe), 64'h1);
        check(64'(term_on), 64'h0);
        termination_enable = 1'b0;
        issue(ddr_pin_pkg::CMD_WRITE, 3'h2, 15'h1000, 64'h0123456789ABCDEF, 8'hFF);
        rd(15'h1000, 64'h0123456789ABCDEF, '1);
        check(64'(drops), 64'h1);
        issue(ddr_pin_pkg::CMD_PRECHARGE, 3'h2, 15'h0000);
        idle(12);
        check(64'(opened), 64'h20);
        cke = 1'b0;
        idle(16);
        check(64'(pwr), 64'(ddr_pin_pkg::PWR_PD_ACT));
        cke = 1'b1;
        idle(16);
        check(64'(pwr), 64'(ddr_pin_pkg::PWR_ACTIVE));
        issue(ddr_pin_pkg::CMD_PRECHARGE, 3'h0, 15'h0400);
        idle(12);
        check(64'(opened), 64'h00);
        cke = 1'b0;
        idle(16);
        check(64'(pwr), 64'(ddr_pin_pkg::PWR_PD_PRE));
        issue(ddr_pin_pkg::CMD_ACTIVATE, 3'h3, 15'h0000, 64'h0, 8'h00, 1'b0);
        idle(12);
        check(64'(opened), 64'h00);
        cke = 1'b1;
        idle(16);
        check(64'(pwr), 64'(ddr_pin_pkg::PWR_ACTIVE));
        issue(ddr_pin_pkg::CMD_REFRESH, 3'h0, 15'h0000, 64'h0, 8'h00, 1'b0);
        idle(16);
        check(64'(pwr), 64'(ddr_pin_pkg::PWR_SELF_REF));
        cke = 1'b1;
        idle(16);
        check(64'(pwr), 64'(ddr_pin_pkg::PWR_ACTIVE));
        issue(ddr_pin_pkg::CMD_ACTIVATE, 3'h6, 15'h0000);
        idle(12);
        check(64'(opened), 64'h40);
        rst_n = 1'b0;
        idle(2);
        check(64'(opened), 64'h00);
        summarize();
    end
endmodule // tb_top
